/* File: logic/dlp_top.sv */
// dimming level pwm generator: fuse settings, pwm counter, bypass path
// assumes level codes from an adc on clk_sys, sense pin asynchronous
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "dlp_defs.svh"

module dlp_top #(
    parameter int unsigned PER_200 = `DLP_CLK_HZ / `DLP_F200_HZ,
    parameter int unsigned PER_500 = `DLP_CLK_HZ / `DLP_F500_HZ,
    parameter int unsigned PER_1K = `DLP_CLK_HZ / `DLP_F1K_HZ,
    parameter int unsigned PER_2K = `DLP_CLK_HZ / `DLP_F2K_HZ
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [`DLP_LVL_W-1:0] level_code,
    input wire logic level_valid,
    input wire logic sense_pin,
    input wire logic fuse_programmed,
    input wire logic [1:0] fuse_min_duty,
    input wire logic [1:0] fuse_freq,
    input wire logic fuse_off_at_low_dim,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    output logic pulse_current_output
);

    localparam int unsigned CNT_MAX = (1 << `DLP_CNT_W) - 1;

    if (PER_200 > CNT_MAX || PER_500 > CNT_MAX) begin : g_chk_lo
        $error("pwm period too long for the counter");
    end

    if (PER_1K > CNT_MAX || PER_2K < 2) begin : g_chk_hi
        $error("pwm period out of counter range");
    end

    localparam dlp_pkg::dlp_top_st_t ST_RST = '{
        st: dlp_pkg::DLP_ST_BOOT,
        min_sel: `DLP_MIN_RST,
        frq_sel: `DLP_FRQ_RST,
        off_low: `DLP_OFF_RST,
        tr: 1'h0,
        prg: 1'h0,
        en: `DLP_EN_RST,
        lvl: '0,
        cnt: '0,
        hi: '0,
        out: 1'h0,
        rdata: 32'h0000_0000
    };

    dlp_pkg::dlp_top_st_t q;
    dlp_pkg::dlp_top_st_t d;

    logic sense_s;
    dlp_pkg::dlp_cnt_t per;

    dlp_duty_if dif();

    // sense pin into the clock domain
    dlp_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin(sense_pin),
        .level(sense_s)
    );

    dlp_duty u_duty (
        .dif(dif.calc)
    );

    // period from the frequency selection
    always_comb begin
        case (q.frq_sel)
            `DLP_FRQ_200: per = dlp_pkg::dlp_cnt_t'(PER_200);
            `DLP_FRQ_500: per = dlp_pkg::dlp_cnt_t'(PER_500);
            `DLP_FRQ_1K: per = dlp_pkg::dlp_cnt_t'(PER_1K);
            default: per = dlp_pkg::dlp_cnt_t'(PER_2K);
        endcase
    end

    assign dif.lvl = q.lvl;
    assign dif.min_sel = q.min_sel;
    assign dif.off_low = q.off_low;
    assign dif.period = per;

    always_comb begin
        d = q;
        d.rdata = 32'h0000_0000;

        // latest sampled level code
        if (level_valid) begin
            d.lvl = level_code;
        end

        case (q.st)
            dlp_pkg::DLP_ST_BOOT: begin
                // fuse capture one edge after reset release
                d.prg = fuse_programmed;
                if (fuse_programmed) begin
                    d.min_sel = fuse_min_duty;
                    d.frq_sel = fuse_freq;
                    d.off_low = fuse_off_at_low_dim;
                end else begin
                    d.min_sel = `DLP_MIN_RST;
                    d.frq_sel = `DLP_FRQ_RST;
                    d.off_low = `DLP_OFF_RST;
                end
                d.tr = d.off_low && (d.frq_sel == `DLP_FRQ_2K);
                d.cnt = '0;
                d.hi = '0;
                d.st = dlp_pkg::DLP_ST_RUN;
            end
            dlp_pkg::DLP_ST_RUN: begin
                if (q.cnt >= per - 20'h00001) begin
                    d.cnt = '0;
                    d.hi = dif.hi;
                end else begin
                    d.cnt = q.cnt + 20'h00001;
                end
            end
            default: begin
                d.st = dlp_pkg::DLP_ST_BOOT;
            end
        endcase

        // output stage
        if (q.st != dlp_pkg::DLP_ST_RUN) begin
            d.out = 1'h0;
        end else if (q.tr) begin
            d.out = sense_s && q.en;
        end else begin
            d.out = (d.cnt < d.hi) && q.en;
        end

        // register port
        if (reg_we && reg_addr == `DLP_ADR_CTRL) begin
            d.en = reg_wdata[`DLP_CTRL_EN_BIT];
        end

        if (reg_re) begin
            if (reg_addr == `DLP_ADR_CFG) begin
                d.rdata[`DLP_CFG_MIN_LSB +: 2] = q.min_sel;
                d.rdata[`DLP_CFG_FRQ_LSB +: 2] = q.frq_sel;
                d.rdata[`DLP_CFG_OFF_BIT] = q.off_low;
                d.rdata[`DLP_CFG_TR_BIT] = q.tr;
                d.rdata[`DLP_CFG_PRG_BIT] = q.prg;
            end else if (reg_addr == `DLP_ADR_CTRL) begin
                d.rdata[`DLP_CTRL_EN_BIT] = q.en;
            end else if (reg_addr == `DLP_ADR_DUTY) begin
                d.rdata[`DLP_CNT_W-1:0] = q.hi;
            end else if (reg_addr == `DLP_ADR_LVL) begin
                d.rdata[`DLP_LVL_W-1:0] = q.lvl;
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign pulse_current_output = q.out;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!nrst);

    property p_boot_default;
        (q.st == dlp_pkg::DLP_ST_BOOT && !fuse_programmed) |=>
            (q.min_sel == `DLP_MIN_5PCT && q.frq_sel == `DLP_FRQ_1K
             && !q.off_low);
    endproperty
    a_boot_default: assert property (p_boot_default)
        else $error("unprogrammed defaults not applied");

    property p_min_floor;
        (q.lvl >= `DLP_LVL_LO && q.lvl <= `DLP_LVL_HI) |->
            (dif.hi >= dif.min_cnt && dif.hi <= per);
    endproperty
    a_min_floor: assert property (p_min_floor)
        else $error("duty outside minimum to full range");

    property p_min_ten;
        (q.min_sel == `DLP_MIN_10PCT) |-> (dif.min_cnt == per / 20'h0000A);
    endproperty
    a_min_ten: assert property (p_min_ten)
        else $error("ten percent minimum count wrong");

    property p_wrap;
        (q.st == dlp_pkg::DLP_ST_RUN && q.cnt == per - 20'h00001) |=>
            (q.cnt == '0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("period counter did not wrap");

    property p_cnt_range;
        (q.st == dlp_pkg::DLP_ST_RUN) |-> (q.cnt < per);
    endproperty
    a_cnt_range: assert property (p_cnt_range)
        else $error("period counter past its period");

    property p_fuse_kept;
        (q.st == dlp_pkg::DLP_ST_RUN) |=>
            $stable({q.min_sel, q.frq_sel, q.off_low, q.tr});
    endproperty
    a_fuse_kept: assert property (p_fuse_kept)
        else $error("settings changed after capture");

    property p_pwm_out;
        (q.st == dlp_pkg::DLP_ST_RUN && !q.tr
         && $past(q.st) == dlp_pkg::DLP_ST_RUN) |->
            (q.out == ((q.cnt < q.hi) && $past(q.en)));
    endproperty
    a_pwm_out: assert property (p_pwm_out)
        else $error("pwm output does not follow counter");

    property p_low_off;
        (q.lvl < `DLP_LVL_LO && q.off_low) |-> (dif.hi == '0);
    endproperty
    a_low_off: assert property (p_low_off)
        else $error("dim-to-off not holding output off");

    property p_low_min;
        (q.lvl < `DLP_LVL_LO && !q.off_low) |-> (dif.hi == dif.min_cnt);
    endproperty
    a_low_min: assert property (p_low_min)
        else $error("low level not at minimum duty");

    property p_high_full;
        (q.lvl > `DLP_LVL_HI) |-> (dif.hi == per);
    endproperty
    a_high_full: assert property (p_high_full)
        else $error("high level not at full duty");

    property p_bypass;
        (q.st == dlp_pkg::DLP_ST_RUN && q.tr) |=>
            (q.out == ($past(sense_s) && $past(q.en)));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("transparent output not following sense");

    property p_bypass_cond;
        (q.st == dlp_pkg::DLP_ST_BOOT) |=>
            (q.tr == (q.off_low && q.frq_sel == `DLP_FRQ_2K));
    endproperty
    a_bypass_cond: assert property (p_bypass_cond)
        else $error("transparent mode condition wrong");

    property p_default_run;
        (q.st == dlp_pkg::DLP_ST_RUN && !q.prg) |->
            (q.min_sel == `DLP_MIN_5PCT && q.frq_sel == `DLP_FRQ_1K
             && !q.off_low && !q.tr);
    endproperty
    a_default_run: assert property (p_default_run)
        else $error("unprogrammed run without default settings");

    property p_boot_dark;
        (q.st == dlp_pkg::DLP_ST_BOOT) |=> !q.out;
    endproperty
    a_boot_dark: assert property (p_boot_dark)
        else $error("output active before settings captured");

    property p_one_volt;
        (q.lvl == `DLP_LVL_LO) |-> (dif.hi == dif.min_cnt);
    endproperty
    a_one_volt: assert property (p_one_volt)
        else $error("duty at the lower end not at minimum");

    property p_nine_volt;
        (q.lvl == `DLP_LVL_HI) |-> (dif.hi == per);
    endproperty
    a_nine_volt: assert property (p_nine_volt)
        else $error("duty at the upper end not full");

    property p_hold_hi;
        (q.cnt != '0) |-> $stable(q.hi);
    endproperty
    a_hold_hi: assert property (p_hold_hi)
        else $error("duty changed inside a period");

endmodule // dlp_top

/* File: logic/dlp_defs.svh */
// constants of the dimming level pwm generator: codes, offsets, resets
// assumes a 100 MHz system clock and a 10 mV level code step
`ifndef DLP_DEFS_SVH
`define DLP_DEFS_SVH

`define DLP_CLK_HZ 100000000
`define DLP_F200_HZ 200
`define DLP_F500_HZ 500
`define DLP_F1K_HZ 1000
`define DLP_F2K_HZ 2000

`define DLP_CNT_W 20
`define DLP_LVL_W 12

// level code, 10 mV per step
`define DLP_LVL_LO 12'h064
`define DLP_LVL_HI 12'h384
`define DLP_LVL_SPAN 32'h0000_0320

`define DLP_MIN_1PCT 2'h0
`define DLP_MIN_2PCT 2'h1
`define DLP_MIN_5PCT 2'h2
`define DLP_MIN_10PCT 2'h3

`define DLP_PCT_1 7'h01
`define DLP_PCT_2 7'h02
`define DLP_PCT_5 7'h05
`define DLP_PCT_10 7'h0A
`define DLP_PCT_FULL 7'h64

`define DLP_FRQ_200 2'h0
`define DLP_FRQ_500 2'h1
`define DLP_FRQ_1K 2'h2
`define DLP_FRQ_2K 2'h3

`define DLP_MIN_RST 2'h2
`define DLP_FRQ_RST 2'h2
`define DLP_OFF_RST 1'h0
`define DLP_EN_RST 1'h1

`define DLP_ADR_CFG 4'h0
`define DLP_ADR_CTRL 4'h4
`define DLP_ADR_DUTY 4'h8
`define DLP_ADR_LVL 4'hC

`define DLP_CFG_MIN_LSB 0
`define DLP_CFG_FRQ_LSB 2
`define DLP_CFG_OFF_BIT 4
`define DLP_CFG_TR_BIT 5
`define DLP_CFG_PRG_BIT 6
`define DLP_CTRL_EN_BIT 0

`endif

/* File: logic/dlp_pkg.sv */
// types of the dimming level pwm generator
// assumes dlp_defs.svh on the include path
`include "dlp_defs.svh"

package dlp_pkg;

    typedef logic [`DLP_CNT_W-1:0] dlp_cnt_t;
    typedef logic [`DLP_LVL_W-1:0] dlp_lvl_t;
    typedef logic [1:0] dlp_sel_t;

    typedef enum logic {DLP_ST_BOOT, DLP_ST_RUN} dlp_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } dlp_sync_st_t;

    typedef struct packed {
        dlp_state_t st;
        dlp_sel_t min_sel;
        dlp_sel_t frq_sel;
        logic off_low;
        logic tr;
        logic prg;
        logic en;
        dlp_lvl_t lvl;
        dlp_cnt_t cnt;
        dlp_cnt_t hi;
        logic out;
        logic [31:0] rdata;
    } dlp_top_st_t;

endpackage

/* File: logic/dlp_duty_if.sv */
// duty request and answer between generator and duty calculator
// assumes both ends on the same clock, answer purely combinational
`timescale 1ns/100ps

interface dlp_duty_if;
    dlp_pkg::dlp_lvl_t lvl;
    dlp_pkg::dlp_sel_t min_sel;
    logic off_low;
    dlp_pkg::dlp_cnt_t period;
    dlp_pkg::dlp_cnt_t hi;
    dlp_pkg::dlp_cnt_t min_cnt;

    modport calc (
        input lvl,
        input min_sel,
        input off_low,
        input period,
        output hi,
        output min_cnt
    );

    modport user (
        output lvl,
        output min_sel,
        output off_low,
        output period,
        input hi,
        input min_cnt
    );
endinterface

/* File: logic/dlp_sync.sv */
// two flip-flop synchroniser for one pin level
// assumes a synchronous active low reset on clk_sys
`timescale 1ns/100ps

module dlp_sync (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);

    dlp_pkg::dlp_sync_st_t q;
    dlp_pkg::dlp_sync_st_t d;

    always_comb begin
        d.s1 = pin;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;

endmodule // dlp_sync

/* File: logic/dlp_duty.sv */
// high time of one pwm period from level code and minimum duty
// assumes period up to 2^20 and level code in 10 mV steps
`timescale 1ns/100ps
`include "dlp_defs.svh"

module dlp_duty (
    dlp_duty_if.calc dif
);

    always_comb begin
        logic [6:0] pct;
        logic [26:0] minp;
        logic [31:0] prod;
        dlp_pkg::dlp_cnt_t minc;
        dlp_pkg::dlp_cnt_t raw;
        pct = `DLP_PCT_5;
        minp = '0;
        prod = '0;
        minc = '0;
        raw = '0;
        case (dif.min_sel)
            `DLP_MIN_1PCT: pct = `DLP_PCT_1;
            `DLP_MIN_2PCT: pct = `DLP_PCT_2;
            `DLP_MIN_5PCT: pct = `DLP_PCT_5;
            default: pct = `DLP_PCT_10;
        endcase
        minp = 27'(dif.period) * 27'(pct);
        minc = dlp_pkg::dlp_cnt_t'(minp / 27'(`DLP_PCT_FULL));
        prod = 32'(dif.lvl - `DLP_LVL_LO) * 32'(dif.period);
        raw = dlp_pkg::dlp_cnt_t'(prod / `DLP_LVL_SPAN);
        if (dif.lvl < `DLP_LVL_LO) begin
            dif.hi = dif.off_low ? '0 : minc;
        end else if (dif.lvl > `DLP_LVL_HI) begin
            dif.hi = dif.period;
        end else if (raw < minc) begin
            dif.hi = minc;
        end else begin
            dif.hi = raw;
        end
        dif.min_cnt = minc;
    end

endmodule // dlp_duty

/* File: tb/dlp_opto_model.sv */
// opto-coupler input side: measures pulse high time and period
// assumes the pin is sampled on clk_sys rising edges
`timescale 1ns/100ps

module dlp_opto_model (
    input wire logic clk_sys,
    input wire logic led_in,
    output int hi_n,
    output int per_n
);
    int hc = 0;
    int pc = 0;
    logic last = 1'b0;

    initial begin
        hi_n = 0;
        per_n = 0;
    end

    // latch high time and period at each rising edge
    always @(posedge clk_sys) begin
        if (led_in && !last) begin
            hi_n <= hc;
            per_n <= pc;
            hc <= 1;
            pc <= 1;
        end else begin
            hc <= hc + int'(led_in);
            pc <= pc + 1;
        end
        last <= led_in;
    end
endmodule // dlp_opto_model

/* File: tb/tb.sv */
// self-checking bench of the dimming level pwm generator
// assumes short periods 100/40/20/10 cycles and the opto model
`timescale 1ns/100ps

module tb;
    logic clk_sys = 1'b0;
    logic nrst;
    logic [11:0] level_code;
    logic level_valid, sense_pin, fuse_programmed, fuse_off_at_low_dim;
    logic [1:0] fuse_min_duty, fuse_freq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_we, reg_re, pulse_current_output, re_d;
    int om_hi, om_per, miscompares, compares, cyc;
    int unsigned seed = 110;
    logic [31:0] exp_q[$];
    int per[4] = '{100, 40, 20, 10};
    int pct[4] = '{1, 2, 5, 10};

    dlp_top #(.PER_200(100), .PER_500(40), .PER_1K(20), .PER_2K(10)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .level_code(level_code),
        .level_valid(level_valid), .sense_pin(sense_pin),
        .fuse_programmed(fuse_programmed), .fuse_min_duty(fuse_min_duty),
        .fuse_freq(fuse_freq), .fuse_off_at_low_dim(fuse_off_at_low_dim),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata),
        .pulse_current_output(pulse_current_output)
    );

    dlp_opto_model opto (.clk_sys(clk_sys), .led_in(pulse_current_output),
        .hi_n(om_hi), .per_n(om_per));

    always #5 clk_sys = ~clk_sys;

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int exp_hi(int p, int c, bit off, int l);
        int m;
        int v;
        m = p * c / 100;
        v = (l - 100) * p / 800;
        if (l < 100) return off ? 0 : m;
        if (l > 900) return p;
        return (v < m) ? m : v;
    endfunction

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_o(logic g, logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        tick(1);
        reg_we <= 1'b0;
        tick(1);
    endtask

    task automatic rd(logic [3:0] a, logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_re <= 1'b1;
        tick(1);
        reg_re <= 1'b0;
        tick(1);
    endtask

    task automatic boot(logic p, logic [1:0] m, logic [1:0] f, logic o);
        nrst <= 1'b0;
        fuse_programmed <= p;
        fuse_min_duty <= m;
        fuse_freq <= f;
        fuse_off_at_low_dim <= o;
        tick(5);
        nrst <= 1'b1;
        tick(2);
    endtask

    task automatic lvl(int l);
        level_code <= 12'(l);
        level_valid <= 1'b1;
        tick(1);
        level_valid <= 1'b0;
        tick(1);
    endtask

    task automatic meas(int l, int p, int h);
        lvl(l);
        tick(3 * p + 4);
        rd(4'hC, 32'(l));
        rd(4'h8, 32'(h));
        if (h == 0)
            chk_o(pulse_current_output, 1'b0);
        else if (h == p)
            chk_o(pulse_current_output, 1'b1);
        else begin
            chk(32'(om_hi), 32'(h));
            chk(32'(om_per), 32'(p));
        end
    endtask

    // read answers: oldest note against the data of the next cycle
    always @(posedge clk_sys) begin
        if (re_d)
            chk(reg_rdata, exp_q.pop_front());
        re_d <= reg_re;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        int l, w;
        logic s;
        nrst = 1'b0;
        level_code = 12'h000;
        level_valid = 1'b0;
        sense_pin = 1'b0;
        fuse_programmed = 1'b0;
        fuse_min_duty = 2'h0;
        fuse_freq = 2'h0;
        fuse_off_at_low_dim = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        re_d = 1'b0;
        // unprogrammed fuses: defaults whatever the fuse lines say
        boot(1'b0, 2'h3, 2'h0, 1'b1);
        rd(4'h0, 32'h0000_000A);
        rd(4'h4, 32'h0000_0001);
        meas(50, 20, 1);
        fuse_programmed <= 1'b1;
        fuse_freq <= 2'h3;
        meas(500, 20, 10);
        rd(4'h0, 32'h0000_000A);
        // every minimum and frequency, levels around the clamp
        for (int f = 0; f < 4; f++) begin
            for (int m = 0; m < 4; m++) begin
                boot(1'b1, 2'(m), 2'(f), 1'b0);
                rd(4'h0, {26'h1, 1'b0, 1'b0, 2'(f), 2'(m)});
                for (int k = 0; k < 4; k++) begin
                    l = k == 0 ? rnd() % 100 : k == 1 ? 99 + 8 * pct[m] :
                        k == 2 ? 100 + rnd() % 801 : 901 + rnd() % 100;
                    meas(l, per[f], exp_hi(per[f], pct[m], 1'b0, l));
                end
            end
        end
        // dim-to-off
        boot(1'b1, 2'h3, 2'h2, 1'b1);
        rd(4'h0, 32'h0000_005B);
        meas(50, 20, 0);
        meas(500, 20, 10);
        // output enable, read-only and unmapped places
        boot(1'b1, 2'h2, 2'h0, 1'b0);
        meas(500, 100, 50);
        w = 0;
        while (pulse_current_output !== 1'b0 && w < 300) begin
            tick(1);
            w++;
        end
        while (pulse_current_output !== 1'b1 && w < 300) begin
            tick(1);
            w++;
        end
        chk_o(w < 300, 1'b1);
        lvl(900);
        rd(4'h8, 32'h0000_0032);
        tick(200);
        rd(4'h8, 32'h0000_0064);
        wr(4'h0, 32'h0000_0000);
        rd(4'h0, 32'h0000_0042);
        rd(4'h2, 32'h0);
        wr(4'h4, 32'h0);
        rd(4'h4, 32'h0);
        tick(300);
        chk_o(pulse_current_output, 1'b0);
        wr(4'h4, 32'h1);
        rd(4'h4, 32'h1);
        // transparent: sense copied after three edges, minimum ignored
        boot(1'b1, 2'h3, 2'h3, 1'b1);
        rd(4'h0, 32'h0000_007F);
        s = 1'b0;
        lvl(50);
        for (int i = 0; i < 7; i++) begin
            sense_pin <= ~s;
            tick(3);
            chk_o(pulse_current_output, s);
            tick(1);
            chk_o(pulse_current_output, ~s);
            s = ~s;
            tick(260 + rnd() % 40);
        end
        wr(4'h4, 32'h0);
        tick(4);
        chk_o(pulse_current_output, 1'b0);
        end_sim();
    end
endmodule // tb
